//--- hw/rh_sensor_regs.svh
// Purpose: constants of the humidity/temperature command unit
// Assumes: 50 MHz core clock
// Notes:   definitions only
`ifndef RH_SENSOR_REGS_SVH
`define RH_SENSOR_REGS_SVH
`define DEV_ADDR      7'h40
`define CMD_T_HOLD    8'hE3
`define CMD_H_HOLD    8'hE5
`define CMD_T_POLL    8'hF3
`define CMD_H_POLL    8'hF5
`define CMD_WR_CFG    8'hE6
`define CMD_RD_CFG    8'hE7
`define CMD_SOFT_RST  8'hFE
`define CFG_RES_HI    7
`define CFG_LOWSUP    6
`define CFG_HEATER    2
`define CFG_NO_RELOAD 1
`define CFG_RES_LO    0
`define CFG_RESET     8'h02
`define CRC_POLY      8'h31
`define CRC_INIT      8'h00
`define CLK_KHZ       50000
`define T14_MS        50
`define T13_MS        25
`define T12_MS        13
`define T11_MS        7
`define SRST_MS       15
`define TSU_NS        100
`endif

//--- hw/rh_sensor_pkg.sv
// Purpose: types of the humidity/temperature command unit
// Assumes: nothing
// Notes:   one-hot state codes
package rh_sensor_pkg;
  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_RX   = 6'h02,
    L_RACK = 6'h04,
    L_TX   = 6'h08,
    L_TACK = 6'h10,
    L_HOLD = 6'h20
  } link_state_t;
  typedef enum logic [2:0] {
    RX_HDR  = 3'h1,
    RX_CMD  = 3'h2,
    RX_DATA = 3'h4
  } rx_kind_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_CONV = 3'h2,
    C_RST  = 3'h4
  } core_state_t;
endpackage : rh_sensor_pkg

//--- hw/rh_sensor_cmd_unit.sv
// Purpose: two-wire command unit of a humidity/temperature sensor
// Assumes: LINK_CLK oversamples SCK/SDA; analog codes stable in a cycle
// Notes:   link logic on LINK_CLK, timing and results on CLK
//
// Notes on behaviour
// RULE1: master waits 15 ms after power-up
// RULE2: start is SDA fall while SCK high
// RULE3: stop is SDA rise while SCK high
// RULE4: header holds address 0x40 plus direction
// RULE5: acknowledge each good byte after eighth clock
// RULE6: E3/E5 measure temperature/humidity, clock held
// RULE7: F3/F5 measure temperature/humidity, polled
// RULE8: E6 writes, E7 reads configuration
// RULE9: FE soft reset, done within 15 ms
// RULE10: hold SCK low until measurement ends
// RULE11: polled read header acked only when done
// RULE12: low result bits carry type status
// RULE13: nack after second byte drops checksum
// RULE14: busy poll leaves header unacknowledged
// RULE15: repeated start begins new sequence
// RULE16: underrange or open gives all zeros
// RULE17: overrange or short gives all ones
// RULE18: soft reset keeps heater bit only
// RULE19: master preserves reserved bits on write
// RULE20: low-supply flag refreshed after measurement
// RULE21: bits 7,0 select resolution
// RULE22: fuse reload before measurement unless disabled
// RULE23: conversion time per resolution
// RULE24: checksum CRC-8 0x31, init zero
// RULE25: result MSB byte first, MSB bit first
// RULE26: checksum after acked second byte
// RULE27: one config byte read, next byte written
`timescale 1ns/1ps
`include "rh_sensor_regs.svh"
`default_nettype none
module rh_sensor_cmd_unit #(
  parameter int unsigned CONV14_CYC = `T14_MS * `CLK_KHZ,
  parameter int unsigned CONV13_CYC = `T13_MS * `CLK_KHZ,
  parameter int unsigned CONV12_CYC = `T12_MS * `CLK_KHZ,
  parameter int unsigned CONV11_CYC = `T11_MS * `CLK_KHZ,
  parameter int unsigned SRST_CYC   = `SRST_MS * `CLK_KHZ - 1,
  parameter int unsigned LINK_MHZ   = 166
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        LINK_CLK,
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic [13:0] TEMP_CODE,
  input  wire logic [13:0] HUM_CODE,
  input  wire logic        SENSOR_OPEN,
  input  wire logic        SENSOR_SHORT,
  input  wire logic        LOW_SUPPLY,
  output logic             HEATER_EN,
  output logic             MEASURING
);
  localparam int unsigned TSU_CYC = (`TSU_NS * LINK_MHZ + 999) / 1000;

  // crc-8, one bit at a time as it leaves the pin
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `CRC_POLY : 8'h00);
  endfunction : crc_step

  // byte to send for a given position of the read stream
  function automatic logic [7:0] tx_byte(input logic from_cfg,
                                         input logic [1:0] idx,
                                         input logic [7:0] cfg,
                                         input logic [15:0] res,
                                         input logic [7:0] crc);
    if (from_cfg) tx_byte = cfg;                       // see RULE27
    else if (idx == 2'd0) tx_byte = res[15:8];         // see RULE25
    else if (idx == 2'd1) tx_byte = res[7:0];
    else tx_byte = crc;                                // see RULE26
  endfunction : tx_byte

  //////////////////////////////////////////////////////////////////////
  // link domain
  logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic        dn_s1, dn_s2;
  logic        done_tgl_reg;
  logic [15:0] res_reg;
  logic        low_reg;
  rh_sensor_pkg::link_state_t l_state_reg, l_state_next;
  rh_sensor_pkg::rx_kind_t    kind_reg, kind_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [7:0]  cfg_reg, cfg_next;
  logic [7:0]  crc_reg, crc_next;
  logic [1:0]  idx_reg, idx_next;
  logic [4:0]  su_reg, su_next;
  logic        rw_reg, rw_next, hold_reg, hold_next;
  logic        src_cfg_reg, src_cfg_next, mack_reg, mack_next;
  logic        sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;
  logic        req_tgl_reg, req_tgl_next, req_hum_reg, req_hum_next;
  logic        req_rst_reg, req_rst_next, rdy_d_reg;
  logic [1:0]  req_res_reg, req_res_next;
  logic        scl_rise, scl_fall, start_det, stop_det, rdy;
  logic        is_conv, is_hum, hold_cmd;
  logic [7:0]  nb;

  // pins and done toggle through two flops; pins add a third stage for edge detection
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
      {dn_s1, dn_s2}          <= 2'h0;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {SCK_IN, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {SDA_IN, sda_s1, sda_s2};
      {dn_s1, dn_s2}          <= {done_tgl_reg, dn_s1};
    end
  end

  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;   // see RULE2
  assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;   // see RULE3
  assign rdy       = (dn_s2 == req_tgl_reg);
  assign is_conv   = (cmd_reg == `CMD_T_HOLD) | (cmd_reg == `CMD_H_HOLD) |
                     (cmd_reg == `CMD_T_POLL) | (cmd_reg == `CMD_H_POLL);
  assign hold_cmd  = (cmd_reg == `CMD_T_HOLD) | (cmd_reg == `CMD_H_HOLD);
  assign is_hum    = (shift_reg == `CMD_H_HOLD) |
                     (shift_reg == `CMD_H_POLL);
  assign nb        = tx_byte(src_cfg_reg, idx_reg, cfg_reg, res_reg, crc_reg);

  // byte engine, command decode and configuration register
  always_comb begin
    l_state_next = l_state_reg;
    kind_next    = kind_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    cmd_next     = cmd_reg;
    cfg_next     = cfg_reg;
    crc_next     = crc_reg;
    idx_next     = idx_reg;
    su_next      = su_reg;
    rw_next      = rw_reg;
    hold_next    = hold_reg;
    src_cfg_next = src_cfg_reg;
    mack_next    = mack_reg;
    sda_oe_next  = sda_oe_reg;
    scl_oe_next  = scl_oe_reg;
    req_tgl_next = req_tgl_reg;
    req_hum_next = req_hum_reg;
    req_rst_next = req_rst_reg;
    req_res_next = req_res_reg;
    if (start_det) begin                               // see RULE15
      l_state_next = rh_sensor_pkg::L_RX;
      kind_next    = rh_sensor_pkg::RX_HDR;
      bit_cnt_next = 4'd0;
      sda_oe_next  = 1'b0;
      scl_oe_next  = 1'b0;
    end else if (stop_det) begin
      l_state_next = rh_sensor_pkg::L_IDLE;
      sda_oe_next  = 1'b0;
      scl_oe_next  = 1'b0;
    end else begin
      case (l_state_reg)
        rh_sensor_pkg::L_RX: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_s2};
            bit_cnt_next = bit_cnt_reg + 4'd1;
          end else if (scl_fall && bit_cnt_reg == 4'd8) begin
            // default is acknowledge; refusals fall back to idle
            l_state_next = rh_sensor_pkg::L_RACK;      // see RULE5
            sda_oe_next  = 1'b1;
            bit_cnt_next = 4'd0;
            case (kind_reg)
              rh_sensor_pkg::RX_HDR: begin
                rw_next   = shift_reg[0];
                hold_next = 1'b0;
                idx_next  = 2'd0;
                crc_next  = `CRC_INIT;
                if (shift_reg[7:1] != `DEV_ADDR ||      // see RULE4
                    (!rdy && req_rst_reg)) begin
                  l_state_next = rh_sensor_pkg::L_IDLE;
                  sda_oe_next  = 1'b0;
                end else if (!shift_reg[0]) begin
                  kind_next = rh_sensor_pkg::RX_CMD;
                end else if (cmd_reg == `CMD_RD_CFG) begin
                  src_cfg_next = 1'b1;                 // see RULE27
                end else if (hold_cmd) begin
                  src_cfg_next = 1'b0;
                  hold_next    = 1'b1;                 // see RULE10
                end else if (!rdy || !is_conv) begin
                  l_state_next = rh_sensor_pkg::L_IDLE; // see RULE14
                  sda_oe_next  = 1'b0;
                end else begin
                  src_cfg_next = 1'b0;                 // see RULE11
                end
              end
              rh_sensor_pkg::RX_CMD: begin
                cmd_next = shift_reg;
                case (shift_reg)
                  `CMD_T_HOLD, `CMD_H_HOLD, `CMD_T_POLL,
                  `CMD_H_POLL: begin                   // see RULE6 RULE7
                    if (rdy) begin
                      req_tgl_next = ~req_tgl_reg;
                      req_rst_next = 1'b0;
                      req_hum_next = is_hum;
                      req_res_next = {cfg_reg[`CFG_RES_HI],
                                      cfg_reg[`CFG_RES_LO]};
                      if (!cfg_reg[`CFG_NO_RELOAD]) begin // see RULE22
                        cfg_next = (`CFG_RESET & 8'hBB) |
                                   (cfg_reg & 8'h44);
                        req_res_next = 2'b00;
                      end
                    end
                  end
                  `CMD_WR_CFG: kind_next = rh_sensor_pkg::RX_DATA;
                  `CMD_RD_CFG: kind_next = rh_sensor_pkg::RX_CMD;
                  `CMD_SOFT_RST: begin                 // see RULE9
                    req_tgl_next = ~req_tgl_reg;
                    req_rst_next = 1'b1;
                    cfg_next = (`CFG_RESET & 8'hFB) |  // see RULE18
                               (cfg_reg & 8'h04);
                  end
                  default: begin
                    l_state_next = rh_sensor_pkg::L_IDLE;
                    sda_oe_next  = 1'b0;
                  end
                endcase
              end
              rh_sensor_pkg::RX_DATA: begin
                // low-supply bit is read-only; rest taken as written
                cfg_next = {shift_reg[7], cfg_reg[`CFG_LOWSUP],
                            shift_reg[5:0]};           // see RULE8 RULE21
              end
              default: l_state_next = rh_sensor_pkg::L_IDLE;
            endcase
          end
        end
        rh_sensor_pkg::L_RACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            if (!rw_reg) begin
              l_state_next = rh_sensor_pkg::L_RX;
            end else if (hold_reg) begin
              l_state_next = rh_sensor_pkg::L_HOLD;
              scl_oe_next  = 1'b1;
              su_next      = 5'd0;
            end else begin
              l_state_next = rh_sensor_pkg::L_TX;
              shift_next   = nb;
              sda_oe_next  = ~nb[7];
            end
          end
        end
        rh_sensor_pkg::L_HOLD: begin
          // drive first bit, then keep SCK low for data setup time
          if (rdy) begin
            shift_next  = nb;
            sda_oe_next = ~nb[7];
            su_next     = su_reg + 5'd1;
            if (su_reg >= 5'(TSU_CYC)) begin
              scl_oe_next  = 1'b0;                     // see RULE10
              l_state_next = rh_sensor_pkg::L_TX;
            end
          end
        end
        rh_sensor_pkg::L_TX: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'd1;
            if (!src_cfg_reg && idx_reg != 2'd2)
              crc_next = crc_step(crc_reg, shift_reg[7]); // see RULE24
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'd8) begin
              sda_oe_next  = 1'b0;
              bit_cnt_next = 4'd0;
              l_state_next = rh_sensor_pkg::L_TACK;
            end else begin
              shift_next  = {shift_reg[6:0], 1'b0};    // see RULE25
              sda_oe_next = ~shift_reg[6];
            end
          end
        end
        rh_sensor_pkg::L_TACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s2;
            idx_next  = idx_reg + 2'd1;
          end else if (scl_fall) begin
            // master nack, or stream exhausted: let go of the line
            if (mack_reg && !src_cfg_reg &&
                idx_reg != 2'd3) begin                 // see RULE13
              l_state_next = rh_sensor_pkg::L_TX;      // see RULE26
              shift_next   = nb;
              sda_oe_next  = ~nb[7];
            end else begin
              l_state_next = rh_sensor_pkg::L_IDLE;
            end
          end
        end
        default: l_state_next = rh_sensor_pkg::L_IDLE;
      endcase
    end
    // flag follows each finished measurement
    if (rdy && !rdy_d_reg && !req_rst_reg)
      cfg_next[`CFG_LOWSUP] = low_reg;                 // see RULE20
  end

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      l_state_reg <= rh_sensor_pkg::L_IDLE;
      kind_reg    <= rh_sensor_pkg::RX_HDR;
      bit_cnt_reg <= 4'd0;
      shift_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      cfg_reg     <= `CFG_RESET;
      crc_reg     <= `CRC_INIT;
      idx_reg     <= 2'd0;
      su_reg      <= 5'd0;
      rw_reg      <= 1'b0;
      hold_reg    <= 1'b0;
      src_cfg_reg <= 1'b0;
      mack_reg    <= 1'b0;
      sda_oe_reg  <= 1'b0;
      scl_oe_reg  <= 1'b0;
      req_tgl_reg <= 1'b0;
      req_hum_reg <= 1'b0;
      req_rst_reg <= 1'b0;
      req_res_reg <= 2'b00;
      rdy_d_reg   <= 1'b1;
    end else begin
      l_state_reg <= l_state_next;
      kind_reg    <= kind_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      cmd_reg     <= cmd_next;
      cfg_reg     <= cfg_next;
      crc_reg     <= crc_next;
      idx_reg     <= idx_next;
      su_reg      <= su_next;
      rw_reg      <= rw_next;
      hold_reg    <= hold_next;
      src_cfg_reg <= src_cfg_next;
      mack_reg    <= mack_next;
      sda_oe_reg  <= sda_oe_next;
      scl_oe_reg  <= scl_oe_next;
      req_tgl_reg <= req_tgl_next;
      req_hum_reg <= req_hum_next;
      req_rst_reg <= req_rst_next;
      req_res_reg <= req_res_next;
      rdy_d_reg   <= rdy;
    end
  end

  // open-drain pins: only ever pulled low
  assign SDA_OUT   = 1'b0;
  assign SCK_OUT   = 1'b0;
  assign SDA_OE    = sda_oe_reg;
  assign SCK_OE    = scl_oe_reg;
  assign HEATER_EN = cfg_reg[`CFG_HEATER];

  //////////////////////////////////////////////////////////////////////
  // core domain
  logic        rq_s1, rq_s2, rq_d;
  logic [30:0] an_s1, an_s2;
  rh_sensor_pkg::core_state_t c_state_reg, c_state_next;
  logic [21:0] cnt_reg, cnt_next;
  logic [15:0] res_next;
  logic        low_next, done_tgl_next, hum_reg, hum_next;
  logic [1:0]  res_sel_reg, res_sel_next;

  // conversion time by resolution code, temperature figures
  function automatic logic [21:0] conv_len(input logic [1:0] r);
    case (r)
      2'b00:   conv_len = 22'(CONV14_CYC - 1);         // see RULE23
      2'b01:   conv_len = 22'(CONV12_CYC - 1);
      2'b10:   conv_len = 22'(CONV13_CYC - 1);
      default: conv_len = 22'(CONV11_CYC - 1);
    endcase
  endfunction : conv_len

  // result word: data left aligned, type in bit 1, diagnostics
  function automatic logic [15:0] fmt(input logic [13:0] code,
                                      input logic hum,
                                      input logic [1:0] r,
                                      input logic open_f,
                                      input logic short_f);
    logic [3:0]  nbits;
    logic [13:0] mask;
    nbits = 4'd0;
    mask  = 14'h0000;
    case (r)
      2'b00:   nbits = hum ? 4'd12 : 4'd14;            // see RULE21
      2'b01:   nbits = hum ? 4'd8  : 4'd12;
      2'b10:   nbits = hum ? 4'd10 : 4'd13;
      default: nbits = 4'd11;
    endcase
    mask = ~(14'h3FFF >> nbits);
    if (open_f || code == 14'h0000) fmt = 16'h0000;     // see RULE16
    else if (short_f || code == 14'h3FFF) fmt = 16'hFFFF; // see RULE17
    else fmt = {code & mask, hum, 1'b0};               // see RULE12
  endfunction : fmt

  // request toggle and analog inputs through two flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {rq_s1, rq_s2, rq_d} <= 3'h0;
      an_s1 <= 31'h0;
      an_s2 <= 31'h0;
    end else begin
      {rq_s1, rq_s2, rq_d} <= {req_tgl_reg, rq_s1, rq_s2};
      an_s1 <= {TEMP_CODE, HUM_CODE, SENSOR_OPEN, SENSOR_SHORT, LOW_SUPPLY};
      an_s2 <= an_s1;
    end
  end

  // request words are stable while the toggle is pending
  always_comb begin
    c_state_next  = c_state_reg;
    cnt_next      = cnt_reg;
    res_next      = res_reg;
    low_next      = low_reg;
    done_tgl_next = done_tgl_reg;
    hum_next      = hum_reg;
    res_sel_next  = res_sel_reg;
    case (c_state_reg)
      rh_sensor_pkg::C_IDLE: begin
        if (rq_s2 ^ rq_d) begin
          hum_next     = req_hum_reg;
          res_sel_next = req_res_reg;
          if (req_rst_reg) begin
            c_state_next = rh_sensor_pkg::C_RST;
            cnt_next     = 22'(SRST_CYC - 1);          // see RULE9
          end else begin
            c_state_next = rh_sensor_pkg::C_CONV;
            cnt_next     = conv_len(req_res_reg);
          end
        end
      end
      rh_sensor_pkg::C_CONV, rh_sensor_pkg::C_RST: begin
        if (cnt_reg == 22'd0) begin
          if (c_state_reg == rh_sensor_pkg::C_CONV) begin
            res_next = fmt(hum_reg ? an_s2[16:3] : an_s2[30:17],
                           hum_reg, res_sel_reg, an_s2[2], an_s2[1]);
            low_next = an_s2[0];
          end
          done_tgl_next = ~done_tgl_reg;
          c_state_next  = rh_sensor_pkg::C_IDLE;
        end else begin
          cnt_next = cnt_reg - 22'd1;
        end
      end
      default: c_state_next = rh_sensor_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      c_state_reg  <= rh_sensor_pkg::C_IDLE;
      cnt_reg      <= 22'd0;
      res_reg      <= 16'h0000;
      low_reg      <= 1'b0;
      done_tgl_reg <= 1'b0;
      hum_reg      <= 1'b0;
      res_sel_reg  <= 2'b00;
    end else begin
      c_state_reg  <= c_state_next;
      cnt_reg      <= cnt_next;
      res_reg      <= res_next;
      low_reg      <= low_next;
      done_tgl_reg <= done_tgl_next;
      hum_reg      <= hum_next;
      res_sel_reg  <= res_sel_next;
    end
  end

  assign MEASURING = (c_state_reg != rh_sensor_pkg::C_IDLE);
endmodule : rh_sensor_cmd_unit
`default_nettype wire

//--- testbench/rh_cmd_unit_assertions.sv
// Purpose: port checks of the sensor command unit
// Assumes: counts scaled as in the bench
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rh_cmd_chk #(
  parameter int unsigned CONV14_CYC = 2000
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic LINK_CLK,
  input wire logic SCK_IN,
  input wire logic SCK_OUT,
  input wire logic SCK_OE,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic HEATER_EN,
  input wire logic MEASURING
);
  ////////////////////////////////////////////////////////////
  // busy spell length; margin covers the code synchronisers
  int unsigned busy_reg;
  int unsigned busy_next;
  always_comb busy_next = MEASURING ? busy_reg + 1 : 0;
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N) busy_reg <= 0;
    else busy_reg <= busy_next;
  ////////////////////////////////////////////////////////////
  chk_open_drain:
    assert property (@(posedge CLK) disable iff (!RESET_N)
      !SCK_OUT && !SDA_OUT) else $error("pin driven high");
  chk_reset_quiet:
    assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(RESET_N) |-> !SDA_OE && !SCK_OE && !MEASURING && !HEATER_EN)
      else $error("outputs active after reset");
  chk_hold_whole:
    assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
      SCK_OE && MEASURING |=> SCK_OE) else $error("hold dropped early");
  chk_hold_end:
    assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
      SCK_OE && !MEASURING |-> ##[0:40] !SCK_OE)
      else $error("hold not released");
  chk_sda_sck_low:
    assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
      $changed(SDA_OE) |-> !SCK_IN) else $error("data moved, clock high");
  chk_ack_width:
    assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
      $rose(SDA_OE) |-> SDA_OE[*8]) else $error("data pulse too short");
  chk_busy_bound:
    assert property (@(posedge CLK) disable iff (!RESET_N)
      busy_reg <= CONV14_CYC + 8) else $error("conversion too long");
  chk_heater_kept:
    assert property (@(posedge CLK) disable iff (!RESET_N)
      MEASURING |-> $stable(HEATER_EN)) else $error("heater changed");
  cover property (@(posedge LINK_CLK) $rose(SCK_OE));
  cover property (@(posedge CLK) $fell(MEASURING));
  cover property (@(posedge CLK) $rose(HEATER_EN));
endmodule : rh_cmd_chk
`default_nettype wire

//--- testbench/bus_master_model.sv
// Purpose: two-wire bus master for the command unit bench
// Assumes: open-drain wires resolved in the bench
// Notes:   200 ns phases, waits out the device clock hold
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic sck_w,
  input  wire logic sda_w,
  output var  logic sck_oe,
  output var  logic sda_oe
);
  localparam int HP = 200;
  initial {sck_oe, sda_oe} = 2'b00;
  ////////////////////////////////////////////////////////////
  // start or repeated start from either clock level
  task automatic start();
    #50 sda_oe = 1'b0;
    #HP sck_oe = 1'b0;
    #HP sda_oe = 1'b1;
    #HP sck_oe = 1'b1;
  endtask : start
  // clock up first, then data
  task automatic stop();
    #50 sda_oe = 1'b1;
    #HP sck_oe = 1'b0;
    #HP sda_oe = 1'b0;
    #HP;
  endtask : stop
  // data moves only well after the clock fell
  task automatic bit_io(input logic b, output logic r);
    int i;
    #50 sda_oe = !b;
    #HP sck_oe = 1'b0;
    for (i = 0; i < 100000 && sck_w !== 1'b1; i++) #10;
    #HP r = sda_w;
    sck_oe = 1'b1;
  endtask : bit_io
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) bit_io(d[k], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr
  // nack after the last wanted byte ends the stream
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int k = 7; k >= 0; k--) bit_io(1'b1, d[k]);
    bit_io(!ack, r);
  endtask : rd
endmodule : bus_master_model
`default_nettype wire

//--- testbench/rh_sensor_cmd_unit_tb.sv
// Purpose: self-checking bench of the sensor command unit
// Assumes: scaled conversion counts, 6 ns link clock
// Notes:   table of conversions, then hand-written cases
`timescale 1ns/1ps
`include "rh_sensor_regs.svh"
`default_nettype none
module rh_sensor_cmd_unit_tb;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [13:0] code;
    logic        op;
    logic        sh;
    logic [15:0] res;
  } row_t;
  logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, a;
  logic [13:0] temp_code = 14'h0000, hum_code = 14'h0000;
  logic s_open = 1'b0, s_short = 1'b0, low_sup = 1'b0;
  logic sck_oe, sda_oe, m_sck, m_sda, heater, busy, sck_w, sda_w;
  int num_errors = 0, n_compared = 0, cyc = 0;
  row_t rows [4] = '{
    '{`CMD_T_HOLD, 14'h1234, 1'b0, 1'b0, 16'h48D0},
    '{`CMD_H_HOLD, 14'h1234, 1'b0, 1'b0, 16'h48D2},
    '{`CMD_T_POLL, 14'h1234, 1'b1, 1'b0, 16'h0000},
    '{`CMD_H_POLL, 14'h1234, 1'b0, 1'b1, 16'hFFFF}};
  // pull-up wires
  assign sck_w = !(sck_oe | m_sck);
  assign sda_w = !(sda_oe | m_sda);
  initial forever #10 clk = !clk;
  initial #1.7 forever #3 link_clk = !link_clk;
  rh_sensor_cmd_unit #(.CONV14_CYC(2000), .CONV13_CYC(1000),
    .CONV12_CYC(600), .CONV11_CYC(400), .SRST_CYC(500)) u_dut (
    .CLK(clk), .RESET_N(reset_n), .LINK_CLK(link_clk),
    .SCK_IN(sck_w), .SCK_OUT(), .SCK_OE(sck_oe),
    .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE(sda_oe),
    .TEMP_CODE(temp_code), .HUM_CODE(hum_code),
    .SENSOR_OPEN(s_open), .SENSOR_SHORT(s_short),
    .LOW_SUPPLY(low_sup), .HEATER_EN(heater), .MEASURING(busy));
  bus_master_model u_mst (.sck_w(sck_w), .sda_w(sda_w),
    .sck_oe(m_sck), .sda_oe(m_sda));
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 15; k >= 0; k--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc8
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic hdr(input logic [7:0] b);
    u_mst.start();
    u_mst.wr(b, a);
  endtask : hdr
  // bounded wait for the core to go idle
  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk);
  endtask : wait_idle
  task automatic cfg_rd(input logic [7:0] e);
    logic [7:0] d;
    hdr(8'h80);
    u_mst.wr(`CMD_RD_CFG, a);
    hdr(8'h81);
    u_mst.rd(1'b0, d);
    u_mst.stop();
    chk("cfg", {8'h00, d}, {8'h00, e});
  endtask : cfg_rd
  task automatic cfg_wr(input logic [7:0] d);
    hdr(8'h80);
    u_mst.wr(`CMD_WR_CFG, a);
    u_mst.wr(d, a);
    u_mst.stop();
  endtask : cfg_wr
  // one conversion; bit 4 of the command marks polling
  task automatic run_conv(input row_t r);
    logic [7:0] m, l, c;
    @(posedge clk);
    #1 temp_code = r.cmd[1] ? r.code : ~r.code;
    hum_code = r.cmd[1] ? ~r.code : r.code;
    s_open = r.op;
    s_short = r.sh;
    hdr(8'h80);
    u_mst.wr(r.cmd, a);
    chk("cmd_ack", 16'(a), 16'h0001);
    if (r.cmd[4]) begin
      u_mst.stop();
      hdr(8'h81);
      chk("busy_ack", 16'(a), 16'h0000);
      u_mst.stop();
      wait_idle();
    end
    hdr(8'h81);
    chk("rd_ack", 16'(a), 16'h0001);
    u_mst.rd(1'b1, m);
    u_mst.rd(!r.cmd[4], l);
    if (!r.cmd[4]) begin
      u_mst.rd(1'b0, c);
      chk("crc", 16'(c), 16'(crc8({m, l})));
    end
    u_mst.stop();
    chk("result", {m, l}, r.res);
    wait_idle();
  endtask : run_conv
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (50) @(posedge clk);
    chk("idle", {14'h0000, heater, busy}, 16'h0000);
    foreach (rows[i]) run_conv(rows[i]);
    cfg_rd(`CFG_RESET);
    cfg_wr(8'h07);
    chk("heater", 16'(heater), 16'h0001);
    cfg_rd(8'h07);
    run_conv(row_t'{`CMD_T_HOLD, 14'h1235, 1'b0, 1'b0, 16'h48D0});
    hdr(8'h80);
    u_mst.wr(`CMD_SOFT_RST, a);
    u_mst.stop();
    wait_idle();
    chk("heater", 16'(heater), 16'h0001);
    cfg_rd(8'h06);
    hdr(8'h82);
    chk("bad_addr", 16'(a), 16'h0000);
    hdr(8'h80);
    u_mst.wr(8'h00, a);
    chk("bad_cmd", 16'(a), 16'h0000);
    u_mst.stop();
    cfg_wr(8'h84);
    @(posedge clk);
    #1 low_sup = 1'b1;
    run_conv(row_t'{`CMD_T_POLL, 14'h1235, 1'b0, 1'b0, 16'h48D4});
    cfg_rd(8'h46);
    report_and_stop();
  end
endmodule : rh_sensor_cmd_unit_tb
bind rh_sensor_cmd_unit rh_cmd_chk #(.CONV14_CYC(CONV14_CYC)) u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .LINK_CLK(LINK_CLK), .SCK_IN(SCK_IN),
  .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .HEATER_EN(HEATER_EN), .MEASURING(MEASURING));
`default_nettype wire
